// ===== logic/tcw_regs.vh
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
// register word indices (byte address = index << 2)
`define TCW_ADDR_CTRL 4'h0
`define TCW_ADDR_MODE 4'h1
`define TCW_ADDR_COUNT 4'h4
`define TCW_ADDR_CAP_A 4'h5
`define TCW_ADDR_CAP_B 4'h6
`define TCW_ADDR_PERIOD 4'h7
`define TCW_ADDR_STATUS 4'h8
// control command bits
`define TCW_CTRL_CLKEN 0
`define TCW_CTRL_CLKDIS 1
`define TCW_CTRL_SWTRG 2
// mode register fields, common
`define TCW_MODE_CLKSEL_LO 0
`define TCW_MODE_CLKI 3
`define TCW_MODE_PTRG 14
`define TCW_MODE_WAVE 15
// capture mode fields
`define TCW_MODE_LDBSTOP 6
`define TCW_MODE_LDBDIS 7
`define TCW_MODE_TRGEDG_LO 8
`define TCW_MODE_TRGSEL 10
`define TCW_MODE_LDA_LO 16
`define TCW_MODE_LDB_LO 18
// waveform mode fields
`define TCW_MODE_STOPP 6
`define TCW_MODE_DISP 7
`define TCW_MODE_EVEDG_LO 8
`define TCW_MODE_EVSEL_LO 10
`define TCW_MODE_EVTRG 12
`define TCW_MODE_AMATCH_LO 16
`define TCW_MODE_APER_LO 18
`define TCW_MODE_AEVT_LO 20
`define TCW_MODE_ASOFT_LO 22
`define TCW_MODE_BMATCH_LO 24
`define TCW_MODE_BPER_LO 26
`define TCW_MODE_BEVT_LO 28
`define TCW_MODE_BSOFT_LO 30
// status bits
`define TCW_ST_OVF 0
`define TCW_ST_LOVR 1
`define TCW_ST_MATCHA 2
`define TCW_ST_MATCHB 3
`define TCW_ST_PERIOD 4
`define TCW_ST_LDA 5
`define TCW_ST_LDB 6
`define TCW_ST_ETRG 7
`define TCW_ST_CLKSTA 16
// action codes
`define TCW_ACT_NONE 2'h0
`define TCW_ACT_SET 2'h1
`define TCW_ACT_CLR 2'h2
`define TCW_ACT_TOG 2'h3
// reset values
`define TCW_RST_MODE 32'h00000000
`define TCW_RST_WORD16 16'h0000
`endif

// ===== logic/tcw_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "tcw_regs.vh"
module tcw_channel
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire [5:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   input wire sync_trigger_in,
   input wire ext_clock_0_in,
   input wire ext_clock_1_in,
   input wire ext_clock_2_in,
   input wire io_line_a_in,
   output reg io_line_a_out,
   output wire io_line_a_oe_out,
   input wire io_line_b_in,
   output reg io_line_b_out,
   output wire io_line_b_oe_out
);
// ==========================================
// bus slave
// ==========================================
// one wait cycle on reads keeps read data registered
reg rd_done_r;
wire [3:0] idx = avs_address_in[5:2];
wire wr_hit = avs_write_in;
// flags and unread marks clear on the edge that latches read data, so nothing set later is lost
wire rd_take = avs_read_in & ~rd_done_r;
assign avs_waitrequest_out = avs_read_in & ~rd_done_r;
reg [31:0] channel_mode_reg_r;
reg [15:0] count_r;
reg [15:0] compare_capture_a_r;
reg [15:0] compare_capture_b_r;
reg [15:0] period_compare_reg_r;
reg [7:0] channel_status_reg_r;
reg clk_en_r;
reg clk_run_r;
reg unread_a_r;
reg unread_b_r;
reg wave_a_r;
reg wave_b_r;
wire wave = channel_mode_reg_r[`TCW_MODE_WAVE];
wire [31:0] wdata = avs_writedata_in & {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
wire cmd_wr = wr_hit & (idx == `TCW_ADDR_CTRL);
wire sw_trg = cmd_wr & wdata[`TCW_CTRL_SWTRG];
wire status_rd = rd_take & (idx == `TCW_ADDR_STATUS);
// ==========================================
// input synchronisers
// ==========================================
reg [4:0] sync1_r;
reg [4:0] sync2_r;
reg [4:0] prev_r;
// no reset: chain fills from the pins during reset, so a high pin gives no false edge afterwards
always @(posedge clk_sys_in)
begin
   sync1_r <= {io_line_b_in, io_line_a_in, ext_clock_2_in, ext_clock_1_in, ext_clock_0_in};
   sync2_r <= sync1_r;
   prev_r <= sync2_r;
end
wire [4:0] rise = sync2_r & ~prev_r;
wire [4:0] fall = ~sync2_r & prev_r;
function edge_hit;
   input [1:0] sel;
   input r;
   input f;
   begin
      edge_hit = (sel[0] & r) | (sel[1] & f);
   end
endfunction
// ==========================================
// counting clock and events
// ==========================================
// internal prescaler taps of the system clock
reg [9:0] presc_r;
always @(posedge clk_sys_in)
begin
   if (reset_in)
      presc_r <= 10'h000;
   else
      presc_r <= presc_r + 10'h001;
end
wire [2:0] clk_sel = channel_mode_reg_r[`TCW_MODE_CLKSEL_LO +: 3];
wire clki = channel_mode_reg_r[`TCW_MODE_CLKI];
reg tick;
always @*
begin
   case (clk_sel)
      3'h0: tick = presc_r[0] == 1'b1;
      3'h1: tick = presc_r[2:0] == 3'h7;
      3'h2: tick = presc_r[4:0] == 5'h1F;
      3'h3: tick = presc_r[6:0] == 7'h7F;
      3'h4: tick = presc_r == 10'h3FF;
      3'h5: tick = clki ? fall[0] : rise[0];
      3'h6: tick = clki ? fall[1] : rise[1];
      default: tick = clki ? fall[2] : rise[2];
   endcase
end
// capture external trigger; line a or b by select bit
wire cap_trg_line_a = channel_mode_reg_r[`TCW_MODE_TRGSEL];
wire cap_trg = ~wave & (cap_trg_line_a ? edge_hit(channel_mode_reg_r[`TCW_MODE_TRGEDG_LO +: 2], rise[3], fall[3])
   : edge_hit(channel_mode_reg_r[`TCW_MODE_TRGEDG_LO +: 2], rise[4], fall[4]));
// waveform event source
wire [1:0] ev_sel = channel_mode_reg_r[`TCW_MODE_EVSEL_LO +: 2];
reg ev_rise;
reg ev_fall;
always @*
begin
   case (ev_sel)
      2'h0:
      begin
         ev_rise = rise[4];
         ev_fall = fall[4];
      end
      2'h1:
      begin
         ev_rise = rise[0];
         ev_fall = fall[0];
      end
      2'h2:
      begin
         ev_rise = rise[1];
         ev_fall = fall[1];
      end
      default:
      begin
         ev_rise = rise[2];
         ev_fall = fall[2];
      end
   endcase
end
wire ext_event = wave & edge_hit(channel_mode_reg_r[`TCW_MODE_EVEDG_LO +: 2], ev_rise, ev_fall);
wire ev_trg = ext_event & channel_mode_reg_r[`TCW_MODE_EVTRG];
wire ext_trg = cap_trg | ev_trg;
// compare matches sampled on counter value change
reg [15:0] last_cnt_r;
wire cnt_changed = count_r != last_cnt_r;
wire match_c = cnt_changed & (count_r == period_compare_reg_r);
wire match_a = wave & cnt_changed & (count_r == compare_capture_a_r);
wire match_b = wave & cnt_changed & (count_r == compare_capture_b_r);
wire per_trg = match_c & channel_mode_reg_r[`TCW_MODE_PTRG];
wire any_trg = sw_trg | sync_trigger_in | per_trg | ext_trg;
// capture loads
wire lda_edge = ~wave & edge_hit(channel_mode_reg_r[`TCW_MODE_LDA_LO +: 2], rise[3], fall[3]);
wire ldb_edge = ~wave & edge_hit(channel_mode_reg_r[`TCW_MODE_LDB_LO +: 2], rise[3], fall[3]);
// sequencing: a may load when not armed_b; b only when armed_b
reg armed_b_r;
wire load_a = lda_edge & ~armed_b_r;
wire load_b = ldb_edge & armed_b_r;
wire overrun = (load_a & unread_a_r) | (load_b & unread_b_r);
wire ovf = tick & clk_run_r & clk_en_r & (count_r == 16'hFFFF);
// ==========================================
// counter and clock control
// ==========================================
wire stop_c = wave & match_c & channel_mode_reg_r[`TCW_MODE_STOPP];
wire dis_c = wave & match_c & channel_mode_reg_r[`TCW_MODE_DISP];
wire stop_b = ~wave & load_b & channel_mode_reg_r[`TCW_MODE_LDBSTOP];
wire dis_b = ~wave & load_b & channel_mode_reg_r[`TCW_MODE_LDBDIS];
reg trg_pend_r;
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      count_r <= `TCW_RST_WORD16;
      last_cnt_r <= 16'hFFFF;
      clk_en_r <= 1'b0;
      clk_run_r <= 1'b0;
      trg_pend_r <= 1'b0;
      armed_b_r <= 1'b0;
   end
   else
   begin
      last_cnt_r <= count_r;
      if (cmd_wr & wdata[`TCW_CTRL_CLKDIS] | dis_c | dis_b)
         clk_en_r <= 1'b0;
      else if (cmd_wr & wdata[`TCW_CTRL_CLKEN])
         clk_en_r <= 1'b1;
      // trigger beats stop; it sets run and pends the clear even while disabled, counting waits for enable
      if (any_trg)
         clk_run_r <= 1'b1;
      else if (stop_c | stop_b)
         clk_run_r <= 1'b0;
      // counter clears on next valid edge after a trigger
      if (any_trg)
         trg_pend_r <= 1'b1;
      else if (tick & clk_run_r & clk_en_r)
         trg_pend_r <= 1'b0;
      if (wr_hit & (idx == `TCW_ADDR_COUNT))
         count_r <= wdata[15:0];
      else if (tick & clk_run_r & clk_en_r)
         count_r <= (trg_pend_r | any_trg) ? 16'h0000 : count_r + 16'h0001;
      if (any_trg)
         armed_b_r <= 1'b0;
      else if (load_b)
         armed_b_r <= 1'b0;
      else if (load_a)
         armed_b_r <= 1'b1;
   end
end
// ==========================================
// registers and status
// ==========================================
wire cap_rd_a = rd_take & (idx == `TCW_ADDR_CAP_A);
wire cap_rd_b = rd_take & (idx == `TCW_ADDR_CAP_B);
wire [7:0] st_set;
assign st_set[`TCW_ST_OVF] = ovf;
assign st_set[`TCW_ST_LOVR] = overrun;
assign st_set[`TCW_ST_MATCHA] = match_a;
assign st_set[`TCW_ST_MATCHB] = match_b;
assign st_set[`TCW_ST_PERIOD] = match_c;
assign st_set[`TCW_ST_LDA] = load_a;
assign st_set[`TCW_ST_LDB] = load_b;
assign st_set[`TCW_ST_ETRG] = ext_trg;
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      rd_done_r <= 1'b0;
      channel_mode_reg_r <= `TCW_RST_MODE;
      compare_capture_a_r <= `TCW_RST_WORD16;
      compare_capture_b_r <= `TCW_RST_WORD16;
      period_compare_reg_r <= `TCW_RST_WORD16;
      channel_status_reg_r <= 8'h00;
      unread_a_r <= 1'b0;
      unread_b_r <= 1'b0;
   end
   else
   begin
      rd_done_r <= avs_read_in & ~rd_done_r;
      if (wr_hit & (idx == `TCW_ADDR_MODE))
         channel_mode_reg_r <= wdata;
      if (wr_hit & (idx == `TCW_ADDR_PERIOD))
         period_compare_reg_r <= wdata[15:0];
      // capture values are read-only in capture mode
      if (load_a)
         compare_capture_a_r <= count_r;
      else if (wave & wr_hit & (idx == `TCW_ADDR_CAP_A))
         compare_capture_a_r <= wdata[15:0];
      if (load_b)
         compare_capture_b_r <= count_r;
      else if (wave & wr_hit & (idx == `TCW_ADDR_CAP_B))
         compare_capture_b_r <= wdata[15:0];
      unread_a_r <= load_a | (unread_a_r & ~cap_rd_a);
      unread_b_r <= load_b | (unread_b_r & ~cap_rd_b);
      // set wins over the clear done by a status read
      channel_status_reg_r <= st_set | (status_rd ? 8'h00 : channel_status_reg_r);
   end
end
always @(posedge clk_sys_in)
begin
   if (reset_in)
      avs_readdata_out <= 32'h00000000;
   else if (avs_read_in & ~rd_done_r)
   begin
      case (idx)
         `TCW_ADDR_MODE: avs_readdata_out <= channel_mode_reg_r;
         `TCW_ADDR_COUNT: avs_readdata_out <= {16'h0000, count_r};
         `TCW_ADDR_CAP_A: avs_readdata_out <= {16'h0000, compare_capture_a_r};
         `TCW_ADDR_CAP_B: avs_readdata_out <= {16'h0000, compare_capture_b_r};
         `TCW_ADDR_PERIOD: avs_readdata_out <= {16'h0000, period_compare_reg_r};
         `TCW_ADDR_STATUS: avs_readdata_out <= {15'h0000, clk_en_r, 8'h00, channel_status_reg_r};
         default: avs_readdata_out <= 32'h00000000;
      endcase
   end
end
// ==========================================
// output controller
// ==========================================
function [1:0] pick_act;
   input sw;
   input ev;
   input pc;
   input own;
   input [7:0] acts;
   begin
      if (sw)
         pick_act = acts[7:6];
      else if (ev)
         pick_act = acts[5:4];
      else if (pc)
         pick_act = acts[3:2];
      else if (own)
         pick_act = acts[1:0];
      else
         pick_act = `TCW_ACT_NONE;
   end
endfunction
function apply_act;
   input [1:0] act;
   input cur;
   begin
      case (act)
         `TCW_ACT_SET: apply_act = 1'b1;
         `TCW_ACT_CLR: apply_act = 1'b0;
         `TCW_ACT_TOG: apply_act = ~cur;
         default: apply_act = cur;
      endcase
   end
endfunction
wire sw_evt = sw_trg | sync_trigger_in;
wire [1:0] act_a = pick_act(sw_evt, ext_event, match_c, match_a,
   channel_mode_reg_r[`TCW_MODE_AMATCH_LO +: 8]);
wire [1:0] act_b = pick_act(sw_evt, ext_event, match_c, match_b,
   channel_mode_reg_r[`TCW_MODE_BMATCH_LO +: 8]);
wire b_drives = wave & (ev_sel != 2'h0);
assign io_line_a_oe_out = wave;
assign io_line_b_oe_out = b_drives;
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      io_line_a_out <= 1'b0;
      io_line_b_out <= 1'b0;
   end
   else if (wave)
   begin
      io_line_a_out <= apply_act(act_a, io_line_a_out);
      if (b_drives)
         io_line_b_out <= apply_act(act_b, io_line_b_out);
   end
end
endmodule
`default_nettype wire

// ===== verif/tcw_io_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// far side of the two io lines
module tcw_io_partner
(
   input wire logic drv_a_in,
   input wire logic drv_b_in,
   input wire logic dut_a_in,
   input wire logic dut_a_oe_in,
   input wire logic dut_b_in,
   input wire logic dut_b_oe_in,
   output wire logic line_a_out,
   output wire logic line_b_out
);
   // far side lets go whenever the channel drives, so no fight on the wire
   assign line_a_out = dut_a_oe_in ? dut_a_in : drv_a_in;
   assign line_b_out = dut_b_oe_in ? dut_b_in : drv_b_in;
endmodule
`default_nettype wire

// ===== verif/tcw_channel_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module tcw_channel_assertions
(
   input wire clk_sys_in,
   input wire reset_in,
   input wire [5:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [31:0] avs_readdata_out,
   input wire avs_waitrequest_out,
   input wire io_line_a_oe_out,
   input wire io_line_b_oe_out
);
   logic [31:0] mode_r;
   wire [3:0] wi = avs_address_in[5:2];
   wire done = avs_read_in && !avs_waitrequest_out;
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);
   // shadow assumes full byte enables, as the bench always drives
   always @(posedge clk_sys_in)
   begin
      if (reset_in)
         mode_r <= 32'h00000000;
      else if (avs_write_in && wi == 4'h1)
         mode_r <= avs_writedata_in;
   end
   a_oe_a_mode: assert property (io_line_a_oe_out == mode_r[15])
      else $error("line a enable wrong");
   a_oe_b_event: assert property (io_line_b_oe_out == (mode_r[15] && mode_r[11:10] != 2'h0))
      else $error("line b enable wrong");
   a_read_wait_once: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 done)
      else $error("read wait wrong");
   a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
      else $error("write waited");
   a_rdata_holds: assert property (!$past(avs_read_in) && !$past(avs_read_in, 2) |-> $stable(avs_readdata_out))
      else $error("read data moved");
   a_mode_read_back: assert property (done && wi == 4'h1 |-> avs_readdata_out == mode_r)
      else $error("mode read back wrong");
   a_unmapped_zero: assert property (done && (wi == 4'h2 || wi == 4'h3 || wi > 4'h8) |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_status_spare: assert property (done && wi == 4'h8 |-> (avs_readdata_out & 32'hFFFEFF00) == 32'h0)
      else $error("status spare bits set");
   cover property (done && wi == 4'h8);
   cover property (done && wi == 4'h5);
   cover property ($rose(io_line_b_oe_out));
endmodule
`default_nettype wire

// ===== verif/tcw_channel_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcw_regs.vh"
// ==========
// bench top
module tcw_channel_test;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wd = 32'h00000000;
   logic [2:0] xc = 3'h0;
   logic pa = 1'b1;
   logic pb = 1'b0;
   wire [31:0] rdat;
   wire rw, la, lb, ao, aoe, bo, boe;
   int errors = 0;
   int samples_checked = 0;
   int exq[$] = '{0, 1, 1, 1, 0};
   always #12.5 clk_sys_in = ~clk_sys_in;
   tcw_channel dut
   (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_address_in(adr), .avs_read_in(rd_s),
      .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
      .avs_waitrequest_out(rw), .sync_trigger_in(1'b0), .ext_clock_0_in(xc[0]), .ext_clock_1_in(xc[1]),
      .ext_clock_2_in(xc[2]), .io_line_a_in(la), .io_line_a_out(ao), .io_line_a_oe_out(aoe),
      .io_line_b_in(lb), .io_line_b_out(bo), .io_line_b_oe_out(boe)
   );
   tcw_io_partner u_far
   (
      .drv_a_in(pa), .drv_b_in(pb), .dut_a_in(ao), .dut_a_oe_in(aoe), .dut_b_in(bo),
      .dut_b_oe_in(boe), .line_a_out(la), .line_b_out(lb)
   );
   // ==========
   // bus and check tasks
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic wt;
      int n;
      n = 0;
      @(posedge clk_sys_in);
      while (rw !== 1'b0)
      begin
         n++;
         if (n > 50)
         begin
            errors++;
            summarize();
         end
         @(posedge clk_sys_in);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      adr <= {a, 2'h0};
      wd <= d;
      wr_s <= 1'b1;
      wt();
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      adr <= {a, 2'h0};
      rd_s <= 1'b1;
      wt();
      d = rdat;
      rd_s <= 1'b0;
   endtask
   // counts edges until line a reaches a level; bounded so a stuck output ends the run
   task automatic wl(input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
         if (n > 400)
         begin
            errors++;
            summarize();
         end
      end
      while (ao !== v);
   endtask
   // ==========
   // scenarios
   initial
   begin
      int n, p, m;
      logic [31:0] r, ca;
      logic v;
      void'($urandom(32'h1c68));
      tk(8);
      reset_in <= 1'b0;
      rd(`TCW_ADDR_MODE, r);
      chk(r, `TCW_RST_MODE);
      chk({aoe, boe}, 32'h0);
      rd(4'h3, r);
      chk(r, 32'h0);
      $display("reset test done");
      // a on rising, b on falling edge of line a
      wr(`TCW_ADDR_MODE, 32'h00090000);
      wr(`TCW_ADDR_CTRL, 32'h00000005);
      fork
      begin
         tk(20);
         pa <= 1'b0;
         tk(20);
         pa <= 1'b1;
         tk(40);
         pa <= 1'b0;
         tk(40);
         pa <= 1'b1;
      end
      join_none
      tk(50);
      rd(`TCW_ADDR_STATUS, r);
      chk(r & 32'h60, 32'h20);
      tk(80);
      rd(`TCW_ADDR_STATUS, r);
      chk(r & 32'h62, 32'h62);
      rd(`TCW_ADDR_STATUS, r);
      chk(r & 32'h62, 32'h0);
      rd(`TCW_ADDR_CAP_B, r);
      rd(`TCW_ADDR_CAP_A, ca);
      chk((ca - r) & 32'hFFFF, 32'h14);
      wr(`TCW_ADDR_CAP_A, 32'h00001234);
      rd(`TCW_ADDR_CAP_A, r);
      chk(r, ca);
      $display("capture test done");
      for (n = 0; n < 5; n++)
      begin
         wr(`TCW_ADDR_MODE, n < 4 ? n << 8 : 32'h00000700);
         rd(`TCW_ADDR_STATUS, r);
         pb <= 1'b1;
         tk(8);
         pb <= 1'b0;
         tk(8);
         rd(`TCW_ADDR_STATUS, r);
         chk(r[7], exq[n]);
      end
      wr(`TCW_ADDR_COUNT, 32'h0000FFF0);
      rd(`TCW_ADDR_STATUS, r);
      tk(40);
      rd(`TCW_ADDR_STATUS, r);
      chk(r & 32'h1, 32'h1);
      rd(`TCW_ADDR_COUNT, ca);
      tk(21);
      rd(`TCW_ADDR_COUNT, r);
      chk((r - ca) & 32'hFFFF, 32'hC);
      $display("trigger test done");
      p = 16 + $urandom % 32;
      m = p / 2;
      wr(`TCW_ADDR_MODE, 32'h0009C400);
      wr(`TCW_ADDR_CAP_A, m);
      wr(`TCW_ADDR_PERIOD, p);
      wr(`TCW_ADDR_CTRL, 32'h00000005);
      chk({aoe, boe}, 32'h3);
      wl(1'b0, n);
      wl(1'b1, n);
      wl(1'b0, n);
      chk(n, 2 * (p - m));
      wl(1'b1, n);
      chk(n, 2 * (m + 1));
      rd(`TCW_ADDR_STATUS, r);
      chk(r & 32'h14, 32'h14);
      wr(`TCW_ADDR_MODE, 32'h00008000);
      tk(1);
      chk({aoe, boe}, 32'h2);
      $display("waveform test done");
      for (n = 0; n < 3; n++)
      begin
         wr(`TCW_ADDR_MODE, 32'h00308100 | (n + 1) << 10);
         tk(4);
         v = ao;
         xc[n] <= 1'b1;
         tk(8);
         chk(ao, !v);
         xc[n] <= 1'b0;
         tk(8);
         chk(ao, !v);
      end
      chk(bo, 1'b0);
      $display("event test done");
      summarize();
   end
endmodule
bind tcw_channel tcw_channel_assertions u_chk
(
   .clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .io_line_a_oe_out(io_line_a_oe_out), .io_line_b_oe_out(io_line_b_oe_out)
);
`default_nettype wire
